// File: logic/prio_regs.svh
// Register offsets, field positions and reset values of the priority register bank.
// Assumes inclusion by the bank module and by the bench.
`ifndef PRIO_REGS_SVH
`define PRIO_REGS_SVH
`define PRIO_OFS_CTRL_2 12'h000
`define PRIO_OFS_CTRL_3 12'h004
`define PRIO_OFS_CTRL_4 12'h008
`define PRIO_OFS_CTRL_5 12'h00c
`define PRIO_OFS_CTRL_7 12'h010
`define PRIO_OFS_CTRL_14 12'h014
`define PRIO_OFS_CTRL_15 12'h018
`define PRIO_OFS_ENABLE 12'h01c
`define PRIO_OFS_STATUS 12'h020
`define PRIO_FIELD_RESET 3'h4
`define PRIO_LEVEL_OFF 3'h0
`define PRIO_NUM_SRC 16
`define PRIO_NUM_REGS 7
`define PRIO_ADDR_W 12
// Implemented-bit masks per priority register.
`define PRIO_MASK_2 16'h7777
`define PRIO_MASK_3 16'h0077
`define PRIO_MASK_4 16'h7077
`define PRIO_MASK_5 16'h7707
`define PRIO_MASK_7 16'h0070
`define PRIO_MASK_14 16'h0770
`define PRIO_MASK_15 16'h7000
// Reset values: every implemented field holds binary 100.
`define PRIO_RST_2 16'h4444
`define PRIO_RST_3 16'h0044
`define PRIO_RST_4 16'h4044
`define PRIO_RST_5 16'h4404
`define PRIO_RST_7 16'h0040
`define PRIO_RST_14 16'h0440
`define PRIO_RST_15 16'h4000
`endif

// File: logic/prio_pkg.sv
// Types shared by the priority register bank.
// Assumes prio_regs.svh is on the include path.
package prio_pkg;
   typedef logic [2:0] level_type;
   typedef struct packed {
      logic valid;
      logic [3:0] source;
      level_type level;
   } winner_type;
   typedef struct packed {
      logic pending;
      logic write;
      logic [11:0] addr;
   } bus_phase_type;
   typedef struct packed {
      logic [6:0][15:0] prio;
      logic [15:0] enable;
      bus_phase_type phase;
      winner_type winner;
      logic [31:0] rdata;
   } state_type;
endpackage

// File: logic/prio_bank.sv
// Interrupt priority register bank with an AHB-Lite slave and a priority resolver.
// Assumes one hclk domain; source requests come from logic on hclk.
// Behaviour
// - Field code 111 means level seven, the highest user level.
// - Code 001 is level one and codes 001 to 111 map linearly to levels one to seven.
// - Code 000 disables the source so its request is never taken.
// - Unimplemented bits ignore writes and read as zero.
// - Each implemented field resets to binary 100.
// - Register 2 holds serial rx 14-12, spi event 10-8, spi error 6-4, timer3 2-0.
// - Register 3 holds adc done 6-4 and serial tx 2-0, bits 15-7 unused.
// - Register 4 holds change notify 14-12, i2c master 6-4, i2c slave 2-0.
// - Register 5 holds capture8 14-12, capture7 10-8, ext irq1 2-0.
// - Register 7 holds only ext irq2 at 6-4.
// - Register 14 holds encoder 10-8 and pwm1 6-4.
// - Register 15 holds only pwm1 fault at 14-12, bits 11-0 unused.
// - Software writes and reads back every implemented field unchanged; a read issued back to back with the write returns the old value.
// - After reset every source starts at level four.
// - A request counts only while its enable bit is one.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "prio_regs.svh"

module prio_bank #(
   parameter int NUM_SRC = `PRIO_NUM_SRC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [NUM_SRC-1:0] src_request,
   output logic irq_valid,
   output logic [3:0] irq_source,
   output prio_pkg::level_type irq_level
);

   localparam logic [6:0][15:0] MASKS = {`PRIO_MASK_15, `PRIO_MASK_14, `PRIO_MASK_7,
      `PRIO_MASK_5, `PRIO_MASK_4, `PRIO_MASK_3, `PRIO_MASK_2};
   localparam logic [6:0][15:0] RESETS = {`PRIO_RST_15, `PRIO_RST_14, `PRIO_RST_7,
      `PRIO_RST_5, `PRIO_RST_4, `PRIO_RST_3, `PRIO_RST_2};
   localparam logic [6:0][11:0] OFFSETS = {`PRIO_OFS_CTRL_15, `PRIO_OFS_CTRL_14,
      `PRIO_OFS_CTRL_7, `PRIO_OFS_CTRL_5, `PRIO_OFS_CTRL_4, `PRIO_OFS_CTRL_3,
      `PRIO_OFS_CTRL_2};

   prio_pkg::state_type state_q;
   prio_pkg::state_type state_d;
   prio_pkg::level_type src_level [NUM_SRC];

   // Source order follows the enable register bit positions of this bank.
   assign src_level[0] = state_q.prio[0][14:12];
   assign src_level[1] = state_q.prio[0][10:8];
   assign src_level[2] = state_q.prio[0][6:4];
   assign src_level[3] = state_q.prio[0][2:0];
   assign src_level[4] = state_q.prio[1][6:4];
   assign src_level[5] = state_q.prio[1][2:0];
   assign src_level[6] = state_q.prio[2][14:12];
   assign src_level[7] = state_q.prio[2][6:4];
   assign src_level[8] = state_q.prio[2][2:0];
   assign src_level[9] = state_q.prio[3][14:12];
   assign src_level[10] = state_q.prio[3][10:8];
   assign src_level[11] = state_q.prio[3][2:0];
   assign src_level[12] = state_q.prio[4][6:4];
   assign src_level[13] = state_q.prio[5][10:8];
   assign src_level[14] = state_q.prio[5][6:4];
   assign src_level[15] = state_q.prio[6][14:12];

   logic addr_phase;
   assign addr_phase = hsel && hready && htrans[1];

   always_comb begin
      logic [3:0] idx;
      idx = 4'h0;
      state_d = state_q;
      state_d.rdata = 32'h0000_0000;
      state_d.phase.pending = addr_phase;
      if (addr_phase) begin
         state_d.phase.write = hwrite;
         state_d.phase.addr = haddr[11:0];
      end
      // Writes land in the data phase; unimplemented bits are masked off.
      if (state_q.phase.pending && state_q.phase.write) begin
         if (state_q.phase.addr < `PRIO_OFS_ENABLE && state_q.phase.addr[1:0] == 2'h0) begin
            idx = state_q.phase.addr[5:2];
            state_d.prio[idx[2:0]] = hwdata[15:0] & MASKS[idx[2:0]];
         end else if (state_q.phase.addr == `PRIO_OFS_ENABLE) begin
            state_d.enable = hwdata[15:0];
         end
      end
      // Read data is registered at the address phase so it stands during the data phase.
      if (addr_phase && !hwrite) begin
         if (haddr[11:0] < `PRIO_OFS_ENABLE && haddr[1:0] == 2'h0) begin
            idx = haddr[5:2];
            state_d.rdata = {16'h0000, state_q.prio[idx[2:0]] & MASKS[idx[2:0]]};
         end else if (haddr[11:0] == `PRIO_OFS_ENABLE) begin
            state_d.rdata = {16'h0000, state_q.enable};
         end else if (haddr[11:0] == `PRIO_OFS_STATUS) begin
            state_d.rdata = {21'h0, state_q.winner.valid, 3'h0, state_q.winner.source,
               state_q.winner.level};
         end
      end
      // Resolver: strict greater-than keeps the lowest-numbered source on a tie.
      state_d.winner = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (src_request[i] && state_q.enable[i]
            && src_level[i] != `PRIO_LEVEL_OFF
            && src_level[i] > state_d.winner.level) begin
            state_d.winner.valid = 1'b1;
            state_d.winner.source = 4'(i);
            state_d.winner.level = src_level[i];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q.prio <= RESETS;
         state_q.enable <= 16'h0000;
         state_q.phase <= '0;
         state_q.winner <= '0;
         state_q.rdata <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = state_q.rdata;
   assign irq_valid = state_q.winner.valid;
   assign irq_source = state_q.winner.source;
   assign irq_level = state_q.winner.level;

   reset_fields_a: assert property (@(posedge hclk) $rose(hresetn) |->
      state_q.prio == RESETS) else $error("priority fields not at level four after reset");
   unused_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q.prio & ~MASKS) == '0) else $error("unimplemented priority bits set");
   write_back_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_q.phase.pending && state_q.phase.write && state_q.phase.addr == `PRIO_OFS_CTRL_2
      |=> state_q.prio[0] == ($past(hwdata[15:0]) & `PRIO_MASK_2))
      else $error("write to register 2 not stored");
   read_back_a: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && haddr[11:0] == `PRIO_OFS_CTRL_15
      |=> hrdata == {16'h0000, $past(state_q.prio[6])})
      else $error("register 15 read mismatch");
   disabled_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_valid |-> irq_level != `PRIO_LEVEL_OFF) else $error("disabled level presented");
   enable_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_valid |-> (($past(state_q.enable & src_request) >> irq_source) & 16'h0001) != 16'h0000)
      else $error("source presented without enable");
   highest_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(src_request[0] && state_q.enable[0] && src_level[0] == 3'h7)
      |-> irq_valid && irq_level == 3'h7) else $error("level seven not presented");
   level_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(src_request == 16'h0001 && state_q.enable[0] && src_level[0] == 3'h1)
      |-> irq_valid && irq_level == 3'h1 && irq_source == 4'h0)
      else $error("level one source not presented");
   always_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp) else $error("slave stalled or errored");

   // Each register keeps exactly what the last write to it left, and nothing else moves it.
   for (genvar r = 0; r < `PRIO_NUM_REGS; r++) begin : g_reg_chk
      field_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
         state_q.phase.pending && state_q.phase.write && state_q.phase.addr == OFFSETS[r]
         |=> state_q.prio[r] == ($past(hwdata[15:0]) & MASKS[r]))
         else $error("priority register write not stored");
      field_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
         !(state_q.phase.pending && state_q.phase.write && state_q.phase.addr == OFFSETS[r])
         |=> state_q.prio[r] == $past(state_q.prio[r]))
         else $error("priority register changed without a write");
   end

   // Per source: a blocked source is never shown, and the winner never ranks below an eligible one.
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_src_chk
      src_blocked_a: assert property (@(posedge hclk) disable iff (!hresetn)
         !(src_request[g] && state_q.enable[g] && src_level[g] != `PRIO_LEVEL_OFF)
         |=> !(irq_valid && irq_source == 4'(g)))
         else $error("blocked source presented");
      src_outranked_a: assert property (@(posedge hclk) disable iff (!hresetn)
         src_request[g] && state_q.enable[g] && src_level[g] != `PRIO_LEVEL_OFF
         |=> irq_valid && irq_level >= $past(src_level[g]))
         else $error("higher level source passed over");
   end

   write_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
      state_q.phase.pending && state_q.phase.write);
   read_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
      state_q.phase.pending && !state_q.phase.write);
   irq_cov_c: cover property (@(posedge hclk) disable iff (!hresetn) irq_valid);
   top_cov_c: cover property (@(posedge hclk) disable iff (!hresetn) irq_level == 3'h7);
   status_cov_c: cover property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && haddr[11:0] == `PRIO_OFS_STATUS && state_q.winner.valid);

endmodule

// File: dv/src_model.sv
// Behavioural model of the interrupt sources that sit beside the priority bank.
// Assumes the bench sets the wanted request pattern; requests are clocked on hclk.
`timescale 1ns/1ps
module src_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [15:0] want,
   output logic [15:0] src_request
);
   // Requests leave a flop, as a real peripheral flag would, so they never glitch.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_request <= 16'h0000;
      end else begin
         src_request <= want;
      end
   end
endmodule

// File: dv/test_interrupt_priority_fields.sv
// Self-checking bench for the priority bank: register map over AHB-Lite and resolver.
// Assumes the bank answers with no wait states and src_model drives the requests.
`timescale 1ns/1ps
`include "prio_regs.svh"
module test_interrupt_priority_fields;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, irq_valid;
   logic [3:0] irq_source;
   prio_pkg::level_type irq_level;
   logic [15:0] want, src_request;
   int n_fail = 0;
   int samples_checked = 0;
   logic [11:0] ofs [7] = '{`PRIO_OFS_CTRL_2, `PRIO_OFS_CTRL_3, `PRIO_OFS_CTRL_4,
      `PRIO_OFS_CTRL_5, `PRIO_OFS_CTRL_7, `PRIO_OFS_CTRL_14, `PRIO_OFS_CTRL_15};
   logic [15:0] msk [7] = '{`PRIO_MASK_2, `PRIO_MASK_3, `PRIO_MASK_4, `PRIO_MASK_5,
      `PRIO_MASK_7, `PRIO_MASK_14, `PRIO_MASK_15};
   logic [15:0] rst [7] = '{`PRIO_RST_2, `PRIO_RST_3, `PRIO_RST_4, `PRIO_RST_5,
      `PRIO_RST_7, `PRIO_RST_14, `PRIO_RST_15};
   initial begin
      forever #2.5 hclk = ~hclk;
   end
   prio_bank u_prio_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_request(src_request),
      .irq_valid(irq_valid), .irq_source(irq_source), .irq_level(irq_level));
   src_model u_src_model (.hclk(hclk), .hresetn(hresetn), .want(want),
      .src_request(src_request));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("Error t=%0t got %h exp %h", $time, got, exp);
         n_fail++;
      end
   endtask
   // Both phases wait on hready under a bound, so a stalled slave ends the run instead of hanging.
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h00000, a};
      hwrite <= w;
      k = 0;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_fail++;
         complete_run;
      end
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
      rd = hrdata;
      if (k >= 100) begin
         n_fail++;
         complete_run;
      end
   endtask
   task automatic chk_irq(input logic [7:0] exp);
      chk({24'h0, irq_valid, irq_source, irq_level}, {24'h0, exp});
   endtask
   task automatic t_reset;
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, ofs[i], 32'h0);
         chk(rd, {16'h0000, rst[i]});
      end
      bus(1'b0, `PRIO_OFS_ENABLE, 32'h0);
      chk(rd, 32'h0);
      $display("reset values done");
   endtask
   task automatic t_rw;
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, ofs[i], 32'hffffffff);
         bus(1'b0, ofs[i], 32'h0);
         chk(rd, {16'h0000, msk[i]});
         bus(1'b1, ofs[i], 32'h0);
         bus(1'b0, ofs[i], 32'h0);
         chk(rd, 32'h0);
      end
      bus(1'b1, 12'h024, 32'hffffffff);
      bus(1'b0, 12'h024, 32'h0);
      chk(rd, 32'h0);
      $display("read write done");
   endtask
   task automatic t_resolve;
      logic [15:0] pr [7] = '{16'h0172, 16'h0172, 16'h0172, 16'h0172, 16'h7000, 16'h1000,
         16'h0550};
      logic [15:0] en [7] = '{16'h000f, 16'h000f, 16'h000f, 16'h000b, 16'h0001, 16'h0001,
         16'h000f};
      logic [15:0] rq [7] = '{16'h0001, 16'h0003, 16'h000f, 16'h000f, 16'h0001, 16'h0001,
         16'h0006};
      logic [7:0] ex [7] = '{8'h00, 8'h89, 8'h97, 8'h9a, 8'h87, 8'h81, 8'h8d};
      // First rx 0, spi event 1, spi error 7, timer3 2; then rx alone at 7 and 1; then a tie.
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, `PRIO_OFS_CTRL_2, {16'h0000, pr[i]});
         bus(1'b1, `PRIO_OFS_ENABLE, {16'h0000, en[i]});
         want <= rq[i];
         repeat (3) @(posedge hclk);
         chk_irq(ex[i]);
      end
      $display("resolver done");
   endtask
   task automatic t_map;
      int rg [16] = '{0, 0, 0, 0, 1, 1, 2, 2, 2, 3, 3, 3, 4, 5, 5, 6};
      int ps [16] = '{12, 8, 4, 0, 4, 0, 12, 4, 0, 12, 8, 0, 4, 8, 4, 12};
      // One field at a time at level 5 proves which source each field steers.
      bus(1'b1, `PRIO_OFS_CTRL_2, 32'h0);
      bus(1'b1, `PRIO_OFS_ENABLE, 32'h0000ffff);
      want <= 16'hffff;
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, ofs[rg[i]], 32'h5 << ps[i]);
         repeat (3) @(posedge hclk);
         chk_irq({1'b1, 4'(i), 3'h5});
         bus(1'b0, `PRIO_OFS_STATUS, 32'h0);
         chk(rd, {21'h0, 1'b1, 3'h0, 4'(i), 3'h5});
         bus(1'b1, ofs[rg[i]], 32'h0);
      end
      $display("field map done");
   endtask
   task automatic t_again;
      bus(1'b1, `PRIO_OFS_CTRL_15, 32'h00003000);
      bus(1'b1, `PRIO_OFS_ENABLE, 32'h0000ffff);
      want <= 16'hffff;
      repeat (3) @(posedge hclk);
      chk_irq(8'hfb);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk_irq(8'h00);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      chk_irq(8'h00);
      bus(1'b1, `PRIO_OFS_ENABLE, 32'h0000ffff);
      repeat (3) @(posedge hclk);
      chk_irq(8'h84);
      $display("second reset done");
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      want = 16'h0000;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_rw;
      t_resolve;
      t_map;
      t_again;
      complete_run;
   end
endmodule
